//--- design/wiper_pkg.sv
// Constants and encodings shared by the dual wiper command unit.
package wiper_pkg;

    localparam int          WIPER_W     = 10;
    localparam int          WORD_W      = 24;
    localparam int          OP_MSB      = 23;
    localparam int          OP_LSB      = 20;
    localparam int          ADDR_MSB    = 19;
    localparam int          ADDR_LSB    = 16;
    localparam int          DATA_MSB    = 15;
    localparam logic [9:0]  WIPER_ZERO  = 10'h000;
    localparam logic [9:0]  WIPER_ONE   = 10'h001;
    localparam logic [9:0]  MIDSCALE    = 10'h200;
    localparam logic [9:0]  FULL_SCALE  = 10'h3FF;
    localparam logic [3:0]  ADDR_CH1    = 4'h0;
    localparam logic [3:0]  ADDR_CH2    = 4'h1;
    localparam logic [23:0] WORD_RESET  = 24'h000000;
    localparam logic [5:0]  PAD_ZERO    = 6'h00;
    // Synchroniser order: {sclk, cs_b, sdi, wp_b, preset_b}, all idle levels.
    localparam logic [4:0]  PIN_IDLE    = 5'h0B;
    localparam int          SAVE_TIME_MS = 25;
    localparam int          CLK_MHZ      = 125;
    localparam int          SAVE_CYCLES  = SAVE_TIME_MS * CLK_MHZ * 1000;
    localparam int          SAVE_CNT_W   = 22;

    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_RESTORE   = 4'h1,
        OP_SAVE      = 4'h2,
        OP_STORE     = 4'h3,
        OP_SHR       = 4'h4,
        OP_SHR_ALL   = 4'h5,
        OP_DEC       = 4'h6,
        OP_DEC_ALL   = 4'h7,
        OP_RESTORE_ALL = 4'h8,
        OP_READ_NV   = 4'h9,
        OP_READ_W    = 4'hA,
        OP_WRITE     = 4'hB,
        OP_SHL       = 4'hC,
        OP_SHL_ALL   = 4'hD,
        OP_INC       = 4'hE,
        OP_INC_ALL   = 4'hF
    } op_t;

endpackage : wiper_pkg

//--- design/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [4:0] RST_VAL = 5'h00
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= RST_VAL[WIDTH-1:0];
            q      <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : pin_sync
`default_nettype wire

//--- design/dual_wiper_command_unit.sv
// Command decoder and wiper state for a dual-channel programmable resistor.
//
// Operation
// - Decode all sixteen instruction codes.
// - Write loads addressed wiper, unlimited times.
// - Save copies wiper into its nonvolatile setting.
// - Word B00100 sets channel one quarter scale.
// - Serial output returns the previous word.
// - Word B10200 sets channel two half scale.
// - Power-on loads wipers from nonvolatile settings.
// - Nonvolatile settings default to midscale.
// - Restore one or both wipers from nonvolatile.
// - Preset low forces midscale; release reloads.
// - Write-protect blocks changes except restores, preset.
// - Step up one or both wipers.
// - Step down one or both wipers.
// - Left shift doubles one or both wipers.
// - Right shift halves one or both wipers.
// - Left shift of zero gives one.
// - Left shift at or above midscale saturates.
// - Word is op, address, sixteen data bits.
// - Execute only when chip select rises.
// - Save locks shift register; done flag signals end.
// - Steps and shifts saturate, never wrap.
`timescale 1ns/1ps
`default_nettype none
module dual_wiper_command_unit #(
    parameter int unsigned SAVE_CYCLES = wiper_pkg::SAVE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       sclk,
    input  wire logic       cs_b,
    input  wire logic       sdi,
    input  wire logic       wp_b,
    input  wire logic       preset_input_b,
    output logic            sdo,
    output logic            save_done,
    output logic [9:0]      wiper_register_ch1,
    output logic [9:0]      wiper_register_ch2
);

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic on one wiper code.

    function automatic logic [9:0] step_up(input logic [9:0] v);
        step_up = (v == wiper_pkg::FULL_SCALE) ? v : v + wiper_pkg::WIPER_ONE;
    endfunction : step_up

    function automatic logic [9:0] step_down(input logic [9:0] v);
        step_down = (v == wiper_pkg::WIPER_ZERO) ? v : v - wiper_pkg::WIPER_ONE;
    endfunction : step_down

    function automatic logic [9:0] shift_left(input logic [9:0] v);
        if (v == wiper_pkg::WIPER_ZERO) begin
            shift_left = wiper_pkg::WIPER_ONE;
        end else if (v >= wiper_pkg::MIDSCALE) begin
            shift_left = wiper_pkg::FULL_SCALE;
        end else begin
            shift_left = {v[8:0], 1'b0};
        end
    endfunction : shift_left

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection.

    logic [4:0]  pins_s;
    logic        sclk_s;
    logic        cs_b_s;
    logic        sdi_s;
    logic        wp_b_s;
    logic        preset_b_s;
    logic        sclk_d_r;
    logic        cs_b_d_r;
    logic        preset_b_d_r;
    logic        sclk_rise;
    logic        cs_rise;
    logic        preset_rise;
    logic        protect;

    pin_sync #(
        .WIDTH   (5),
        .RST_VAL (wiper_pkg::PIN_IDLE)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({sclk, cs_b, sdi, wp_b, preset_input_b}),
        .q     (pins_s)
    );

    assign {sclk_s, cs_b_s, sdi_s, wp_b_s, preset_b_s} = pins_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_d_r     <= 1'b0;
            cs_b_d_r     <= 1'b1;
            preset_b_d_r <= 1'b1;
        end else begin
            sclk_d_r     <= sclk_s;
            cs_b_d_r     <= cs_b_s;
            preset_b_d_r <= preset_b_s;
        end
    end

    assign sclk_rise   = sclk_s & ~sclk_d_r;
    assign cs_rise     = cs_b_s & ~cs_b_d_r;
    assign preset_rise = preset_b_s & ~preset_b_d_r;
    assign protect     = ~wp_b_s;

    ////////////////////////////////////////////////////////////////////////////
    // Serial word, decode and execute strobe.

    logic [23:0]           word_r;
    logic                  busy_r;
    logic                  exec;
    wiper_pkg::op_t        op;
    logic [3:0]            addr;
    logic [9:0]            data;
    logic                  addr_ok;
    logic                  ch_sel;
    logic                  por_r;
    logic [9:0]            wiper_r [2];
    logic [9:0]            wiper_nxt [2];
    logic [9:0]            nv_r [2];

    assign op      = wiper_pkg::op_t'(word_r[wiper_pkg::OP_MSB:wiper_pkg::OP_LSB]);
    assign addr    = word_r[wiper_pkg::ADDR_MSB:wiper_pkg::ADDR_LSB];
    assign data    = word_r[9:0];
    assign addr_ok = (addr == wiper_pkg::ADDR_CH1) || (addr == wiper_pkg::ADDR_CH2);
    assign ch_sel  = addr[0];
    // A word finished while a save is running is dropped with the lock.
    assign exec    = cs_rise & ~busy_r;

    // The word stays put after execution, except that reads load their data bits, so the next frame clocks it out.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            word_r <= wiper_pkg::WORD_RESET;
        end else if (exec && addr_ok && op == wiper_pkg::OP_READ_NV) begin
            word_r[wiper_pkg::DATA_MSB:0] <= {wiper_pkg::PAD_ZERO, nv_r[ch_sel]};
        end else if (exec && addr_ok && op == wiper_pkg::OP_READ_W) begin
            word_r[wiper_pkg::DATA_MSB:0] <= {wiper_pkg::PAD_ZERO, wiper_r[ch_sel]};
        end else if (sclk_rise && !cs_b_s && !busy_r) begin
            word_r <= {word_r[22:0], sdi_s};
        end
    end

    assign sdo = word_r[23];

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile settings and save timing.

    logic [21:0] save_cnt_r;
    logic        save_go;

    assign save_go = exec && !protect && addr_ok
                     && (op == wiper_pkg::OP_SAVE || op == wiper_pkg::OP_STORE);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nv_r[0] <= wiper_pkg::MIDSCALE;
            nv_r[1] <= wiper_pkg::MIDSCALE;
        end else if (save_go && op == wiper_pkg::OP_SAVE) begin
            nv_r[ch_sel] <= wiper_r[ch_sel];
        end else if (save_go) begin
            nv_r[ch_sel] <= data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_r     <= 1'b0;
            save_cnt_r <= '0;
        end else if (save_go) begin
            busy_r     <= 1'b1;
            save_cnt_r <= SAVE_CYCLES[21:0] - 22'h000001;
        end else if (busy_r && save_cnt_r == '0) begin
            busy_r     <= 1'b0;
        end else if (busy_r) begin
            save_cnt_r <= save_cnt_r - 22'h000001;
        end
    end

    assign save_done = ~busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Wiper registers.

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            por_r <= 1'b1;
        end else begin
            por_r <= 1'b0;
        end
    end

    // Preset and power-on refresh sit above every command, so that the
    // restore paths stay open even under write-protect.
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            logic hit;
            hit = addr_ok && (ch_sel == ch[0]);
            wiper_nxt[ch] = wiper_r[ch];
            if (por_r) begin
                wiper_nxt[ch] = nv_r[ch];
            end else if (!preset_b_s) begin
                wiper_nxt[ch] = wiper_pkg::MIDSCALE;
            end else if (preset_rise) begin
                wiper_nxt[ch] = nv_r[ch];
            end else if (exec) begin
                unique case (op)
                    wiper_pkg::OP_NOP, wiper_pkg::OP_SAVE, wiper_pkg::OP_STORE,
                    wiper_pkg::OP_READ_NV, wiper_pkg::OP_READ_W: begin
                    end
                    wiper_pkg::OP_RESTORE: begin
                        if (hit) wiper_nxt[ch] = nv_r[ch];
                    end
                    wiper_pkg::OP_RESTORE_ALL: begin
                        wiper_nxt[ch] = nv_r[ch];
                    end
                    wiper_pkg::OP_WRITE: begin
                        if (hit && !protect) wiper_nxt[ch] = data;
                    end
                    wiper_pkg::OP_INC, wiper_pkg::OP_INC_ALL: begin
                        if ((hit || op == wiper_pkg::OP_INC_ALL) && !protect) begin
                            wiper_nxt[ch] = step_up(wiper_r[ch]);
                        end
                    end
                    wiper_pkg::OP_DEC, wiper_pkg::OP_DEC_ALL: begin
                        if ((hit || op == wiper_pkg::OP_DEC_ALL) && !protect) begin
                            wiper_nxt[ch] = step_down(wiper_r[ch]);
                        end
                    end
                    wiper_pkg::OP_SHL, wiper_pkg::OP_SHL_ALL: begin
                        if ((hit || op == wiper_pkg::OP_SHL_ALL) && !protect) begin
                            wiper_nxt[ch] = shift_left(wiper_r[ch]);
                        end
                    end
                    wiper_pkg::OP_SHR, wiper_pkg::OP_SHR_ALL: begin
                        if ((hit || op == wiper_pkg::OP_SHR_ALL) && !protect) begin
                            wiper_nxt[ch] = {1'b0, wiper_r[ch][9:1]};
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wiper_r[0] <= wiper_pkg::MIDSCALE;
            wiper_r[1] <= wiper_pkg::MIDSCALE;
        end else begin
            wiper_r[0] <= wiper_nxt[0];
            wiper_r[1] <= wiper_nxt[1];
        end
    end

    assign wiper_register_ch1 = wiper_r[0];
    assign wiper_register_ch2 = wiper_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic quiet;
    assign quiet = !por_r && preset_b_s && !preset_rise;

    preset_mid_a: assert property (
        !preset_b_s && !por_r |=> wiper_r[0] == wiper_pkg::MIDSCALE
                                  && wiper_r[1] == wiper_pkg::MIDSCALE)
        else $error("Preset low did not force midscale.");

    preset_load_a: assert property (
        preset_rise && !por_r |=> wiper_r[0] == $past(nv_r[0])
                                  && wiper_r[1] == $past(nv_r[1]))
        else $error("Preset release did not reload settings.");

    write_load_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_WRITE
        && addr == wiper_pkg::ADDR_CH2
        |=> wiper_r[1] == $past(word_r[9:0]) && $stable(wiper_r[0]))
        else $error("Write did not load channel two.");

    protect_hold_a: assert property (
        exec && quiet && protect && op != wiper_pkg::OP_RESTORE
        && op != wiper_pkg::OP_RESTORE_ALL
        |=> $stable(wiper_r[0]) && $stable(wiper_r[1]))
        else $error("Wiper changed under write-protect.");

    // The expected codes are spelled out here rather than taken from the
    // step and shift functions, so a fault in those functions still fires.
    step_up_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_INC_ALL
        && wiper_r[0] != wiper_pkg::FULL_SCALE
        |=> wiper_r[0] == $past(wiper_r[0]) + wiper_pkg::WIPER_ONE)
        else $error("Step up did not add one.");

    step_up_sat_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_INC_ALL
        && wiper_r[1] == wiper_pkg::FULL_SCALE
        |=> wiper_r[1] == wiper_pkg::FULL_SCALE)
        else $error("Step up wrapped past full scale.");

    shift_zero_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_SHL_ALL
        && wiper_r[0] == wiper_pkg::WIPER_ZERO
        |=> wiper_r[0] == wiper_pkg::WIPER_ONE)
        else $error("Left shift of zero did not give one.");

    shift_right_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_SHR_ALL
        |=> wiper_r[1] == ($past(wiper_r[1]) >> 1))
        else $error("Right shift did not halve channel two.");

    read_nv_a: assert property (
        exec && op == wiper_pkg::OP_READ_NV && addr == wiper_pkg::ADDR_CH1
        |=> word_r[wiper_pkg::DATA_MSB:0] == {wiper_pkg::PAD_ZERO, $past(nv_r[0])})
        else $error("Readback did not load the saved setting.");

    step_down_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_DEC
        && addr == wiper_pkg::ADDR_CH1 && wiper_r[0] == wiper_pkg::WIPER_ZERO
        |=> wiper_r[0] == wiper_pkg::WIPER_ZERO)
        else $error("Step down wrapped below zero.");

    shift_sat_a: assert property (
        exec && quiet && !protect && op == wiper_pkg::OP_SHL
        && addr == wiper_pkg::ADDR_CH1 && wiper_r[0] >= wiper_pkg::MIDSCALE
        |=> wiper_r[0] == wiper_pkg::FULL_SCALE)
        else $error("Left shift at midscale did not saturate.");

    save_lock_a: assert property (
        busy_r ##1 busy_r |-> $stable(word_r))
        else $error("Shift register moved during save.");

    save_count_a: assert property (
        busy_r && save_cnt_r != '0 |=> busy_r && save_cnt_r == $past(save_cnt_r) - 22'h000001)
        else $error("Save timer misbehaved.");

    save_copy_a: assert property (
        save_go && op == wiper_pkg::OP_SAVE && addr == wiper_pkg::ADDR_CH1
        |=> nv_r[0] == $past(wiper_r[0]) && !save_done)
        else $error("Save did not copy channel one.");

    write_cov_c: cover property (exec && op == wiper_pkg::OP_WRITE && !protect);
    save_end_c: cover property (busy_r ##1 !busy_r);
    preset_c: cover property (preset_rise && !por_r);
    protect_c: cover property (exec && protect && op == wiper_pkg::OP_RESTORE_ALL);
    shift_sat_c: cover property (exec && op == wiper_pkg::OP_SHL_ALL
                                 && wiper_r[1] >= wiper_pkg::MIDSCALE);

endmodule : dual_wiper_command_unit
`default_nettype wire

//--- testbench/spi_master_model.sv
// Serial host model that frames 24-bit words towards the command unit.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_b,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        sdi  = 1'b0;
    end

    // Half of an 80 ns serial period, counted in system cycles.
    task automatic half;
        repeat (5) @(negedge clk);
    endtask : half

    // Sends one word most significant bit first and returns what came back.
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        @(negedge clk);
        cs_b = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = w[i];
            half();
            r[i] = sdo;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_b = 1'b1;
        // The line is left at the inverse so a stale bit cannot pass for data.
        sdi = ~sdi;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : spi_master_model
`default_nettype wire

//--- testbench/test_dual_wiper_command_unit.sv
// Self-checking bench for the dual wiper command unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module test_dual_wiper_command_unit;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wp_b = 1'b1;
    logic        preset_input_b = 1'b1;
    wire logic   sclk;
    wire logic   cs_b;
    wire logic   sdi;
    logic        sdo;
    logic        save_done;
    logic [9:0]  wiper_register_ch1;
    logic [9:0]  wiper_register_ch2;
    logic [23:0] rd;
    int          err_total = 0;
    int          checks = 0;

    always #4 clk = ~clk;

    // A short save time keeps the lock window longer than one frame only.
    dual_wiper_command_unit #(.SAVE_CYCLES(400)) u_dut (
        .clk                (clk),
        .rst_b              (rst_b),
        .sclk               (sclk),
        .cs_b               (cs_b),
        .sdi                (sdi),
        .wp_b               (wp_b),
        .preset_input_b     (preset_input_b),
        .sdo                (sdo),
        .save_done          (save_done),
        .wiper_register_ch1 (wiper_register_ch1),
        .wiper_register_ch2 (wiper_register_ch2)
    );

    spi_master_model u_host (
        .clk  (clk),
        .sclk (sclk),
        .cs_b (cs_b),
        .sdi  (sdi),
        .sdo  (sdo)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic [23:0] w, input logic [9:0] e1, input logic [9:0] e2);
        u_host.xfer(w, rd);
        `CHK("wiper_ch1", e1, wiper_register_ch1)
        `CHK("wiper_ch2", e2, wiper_register_ch2)
    endtask : step

    task automatic wait_save;
        int n;
        n = 0;
        while (save_done !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        `CHK("save_done", 1'b1, save_done)
    endtask : wait_save

    task automatic t_power;
        `CHK("wiper_ch1", 10'h200, wiper_register_ch1)
        `CHK("wiper_ch2", 10'h200, wiper_register_ch2)
        `CHK("save_done", 1'b1, save_done)
    endtask : t_power

    task automatic t_set_save;
        step(24'hB00100, 10'h100, 10'h200);
        step(24'h20ABCD, 10'h100, 10'h200);
        `CHK("sdo_word", 24'hB00100, rd)
        `CHK("save_done", 1'b0, save_done)
        // This frame lands inside the save lock and must be dropped.
        step(24'hB00155, 10'h100, 10'h200);
        wait_save();
        step(24'hB10011, 10'h100, 10'h011);
        // The dropped frame must not have reached the shift register.
        `CHK("sdo_word", 24'h20ABCD, rd)
        step(24'hB10200, 10'h100, 10'h200);
        step(24'h210000, 10'h100, 10'h200);
        `CHK("sdo_word", 24'hB10200, rd)
        wait_save();
        step(24'hB0FC05, 10'h005, 10'h200);
        step(24'h100000, 10'h100, 10'h200);
        step(24'hB10377, 10'h100, 10'h377);
        step(24'h800000, 10'h100, 10'h200);
        step(24'h900000, 10'h100, 10'h200);
        step(24'hA10000, 10'h100, 10'h200);
        `CHK("sdo_nv", 24'h900100, rd)
        step(24'h000000, 10'h100, 10'h200);
        `CHK("sdo_wiper", 24'hA10200, rd)
    endtask : t_set_save

    task automatic t_steps;
        step(24'hB00000, 10'h000, 10'h200);
        step(24'hB103FF, 10'h000, 10'h3FF);
        step(24'h60FFFF, 10'h000, 10'h3FF);
        step(24'hE1AAAA, 10'h000, 10'h3FF);
        step(24'hF00000, 10'h001, 10'h3FF);
        step(24'h700000, 10'h000, 10'h3FE);
        step(24'hC00000, 10'h001, 10'h3FE);
        step(24'hD00000, 10'h002, 10'h3FF);
        step(24'hC11234, 10'h002, 10'h3FF);
        step(24'hE00000, 10'h003, 10'h3FF);
        step(24'h610000, 10'h003, 10'h3FE);
        step(24'h410000, 10'h003, 10'h1FF);
        step(24'h500000, 10'h001, 10'h0FF);
        step(24'h400000, 10'h000, 10'h0FF);
        step(24'h400000, 10'h000, 10'h0FF);
        step(24'hD00000, 10'h001, 10'h1FE);
    endtask : t_steps

    task automatic t_protect;
        wp_b = 1'b0;
        repeat (4) @(negedge clk);
        step(24'hB00222, 10'h001, 10'h1FE);
        step(24'hF00000, 10'h001, 10'h1FE);
        step(24'h200000, 10'h001, 10'h1FE);
        `CHK("save_done", 1'b1, save_done)
        step(24'h100000, 10'h100, 10'h1FE);
        step(24'h800000, 10'h100, 10'h200);
        step(24'h000000, 10'h100, 10'h200);
        wp_b = 1'b1;
        repeat (4) @(negedge clk);
    endtask : t_protect

    task automatic t_preset;
        step(24'h310155, 10'h100, 10'h200);
        wait_save();
        step(24'hB00300, 10'h300, 10'h200);
        preset_input_b = 1'b0;
        repeat (6) @(negedge clk);
        `CHK("wiper_ch1", 10'h200, wiper_register_ch1)
        `CHK("wiper_ch2", 10'h200, wiper_register_ch2)
        preset_input_b = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("wiper_ch1", 10'h100, wiper_register_ch1)
        `CHK("wiper_ch2", 10'h155, wiper_register_ch2)
    endtask : t_preset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_power();
        t_set_save();
        t_steps();
        t_protect();
        t_preset();
        wrap_up();
    end

    // About forty frames and three saves fit well inside this span.
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule : test_dual_wiper_command_unit
`default_nettype wire
